// ===== design/cfg_pin_pkg.sv
// Constants, states and carriers for the configuration pin logic.
// Assumes a 100 MHz ref_clk and a register bus of 32-bit words.
package cfg_pin_pkg;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_PS = 10000;
   localparam int AS_CLK_HALF_NS = 80;
   localparam logic [3:0] AS_HALF_CYC = 4'((AS_CLK_HALF_NS * 1000) / CLK_PERIOD_PS);
   localparam logic [3:0] INIT_CYCLES = 4'h8;
   localparam logic [5:0] AS_CMD_BITS = 6'h20;
   localparam logic [31:0] AS_READ_CMD = 32'h03000000;
   // ************************************************************
   // Registers (byte offsets)
   // ************************************************************
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] LEN_OFS = 4'h4;
   localparam logic [3:0] STATUS_OFS = 4'h8;
   localparam logic [4:0] CTRL_RESET = 5'h00;
   localparam logic [15:0] LEN_RESET = 16'h0010;
   localparam int CTRL_ACTIVE = 0;
   localparam int CTRL_USER_CLK = 1;
   localparam int CTRL_INIT_DONE = 2;
   localparam int CTRL_OE_OVR = 3;
   localparam int CTRL_CLR_OVR = 4;
   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_LOAD = 3'h1,
      ST_RELEASE = 3'h2,
      ST_INIT = 3'h3,
      ST_USER = 3'h4,
      ST_ERROR = 3'h5,
      ST_SENSE = 3'h6
   } cfg_state_t;
   typedef struct packed {
      logic restart_n;
      logic chain_en_n;
      logic cfg_clk;
      logic cfg_data;
      logic done_in;
      logic status_in;
      logic user_clk;
      logic oe_pin;
      logic clr_n;
   } pin_in_t;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } byte_t;
endpackage

// ===== design/pin_sync.sv
// Two-stage synchroniser for all configuration input pins.
// Assumes pins are asynchronous to ref_clk.
`timescale 1ns/1ps
module pin_sync (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire cfg_pin_pkg::pin_in_t pins_in,
   output cfg_pin_pkg::pin_in_t pins_out
);
   typedef struct packed {
      cfg_pin_pkg::pin_in_t meta;
      cfg_pin_pkg::pin_in_t sync;
   } sync_t;
   sync_t st_reg;
   sync_t st_next;
   always_comb begin
      st_next.meta = pins_in;
      st_next.sync = st_reg.meta;
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign pins_out = st_reg.sync;
endmodule // pin_sync

// ===== design/serial_byte_assembler.sv
// Gathers serial configuration bits into bytes, first bit in the LSB.
// Assumes bit_valid pulses come from the same clock domain.
`timescale 1ns/1ps
module serial_byte_assembler (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic clear,
   input wire logic bit_valid,
   input wire logic bit_in,
   output cfg_pin_pkg::byte_t byte_out
);
   typedef struct packed {
      logic [7:0] shift;
      logic [2:0] cnt;
      cfg_pin_pkg::byte_t out;
   } asm_t;
   asm_t st_reg;
   asm_t st_next;
   always_comb begin
      st_next = st_reg;
      st_next.out.valid = 1'b0;
      if (clear) begin
         st_next.cnt = 3'h0;
      end else if (bit_valid) begin
         // Shift right so the earliest bit ends in bit 0
         st_next.shift = {bit_in, st_reg.shift[7:1]};
         st_next.cnt = st_reg.cnt + 3'h1;
         if (st_reg.cnt == 3'h7) begin
            st_next.out.valid = 1'b1;
            st_next.out.data = {bit_in, st_reg.shift[7:1]};
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign byte_out = st_reg.out;
endmodule // serial_byte_assembler

// ===== design/config_pin_handshake.sv
// Configuration pin control: passive and active serial loading, completion
// and status handshakes, initialisation and user-mode overrides.
// Assumes a 100 MHz ref_clk; all pins are asynchronous and synchronised here.
//
// Contract
// - Hold completion line low until loading ends
// - Release completion after clean data, init clock
// - Completion sensed high, initialise, enter user mode
// - External low on completion delays initialisation; the code waits on it in passive mode only, active mode goes straight to init
// - Ignore completion line after initialisation
// - Device drives config clock in active mode
// - Ignore config clock after configuration
// - Drive serial read command to memory
// - Drive active-low memory select in active mode
// - Chain enable out low once configured
// - Optional user clock times initialisation
// - User-mode status low during configuration
// - User-mode status released before and after
// - Output-enable override tri-states all I/O
// - Register-clear override clears all registers
// - Restart falling resets, rising starts configuration
// - Error pulls error status line low
//
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module config_pin_handshake (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic config_restart_n,
   input wire logic chain_enable_n,
   input wire logic serial_config_in,
   input wire logic config_clock_in,
   output logic config_clock_out,
   output logic config_clock_oe,
   input wire logic config_complete_flag_in,
   output logic config_complete_flag_out,
   output logic config_complete_flag_oe,
   input wire logic error_status_in,
   output logic error_status_out,
   output logic error_status_oe,
   output logic init_done_out,
   output logic init_done_oe,
   output logic active_serial_cmd_out,
   output logic flash_select_n,
   output logic chain_enable_out_n,
   input wire logic user_init_clock,
   input wire logic global_output_enable,
   input wire logic global_register_clear_n,
   output logic user_io_tristate,
   output logic user_reg_clear
);
   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      cfg_pin_pkg::cfg_state_t state;
      logic restart_q;
      logic clk_q;
      logic uclk_q;
      logic [3:0] div;
      logic sclk;
      logic [5:0] cmd_cnt;
      logic [31:0] cmd_sh;
      logic [15:0] byte_cnt;
      logic [7:0] xsum;
      logic [3:0] init_cnt;
      logic [4:0] ctrl;
      logic [15:0] len;
      logic err;
      logic wait_r;
      logic [31:0] rdata;
      logic clk_oe;
      logic done_oe;
      logic status_oe;
      logic cmd_out;
      logic cs_n;
      logic ceo_n;
      logic init_oe;
      logic tri_io;
      logic clr_io;
      logic bit_v;
      logic bit_d;
      logic clear_asm;
   } hs_t;
   hs_t st_reg;
   hs_t st_next;
   cfg_pin_pkg::pin_in_t pins_raw;
   cfg_pin_pkg::pin_in_t pins;
   cfg_pin_pkg::byte_t rx_byte;

   function automatic logic [31:0] reg_read(input logic [3:0] addr, input hs_t s);
      logic [31:0] v;
      v = 32'h00000000;
      case (addr)
         cfg_pin_pkg::CTRL_OFS: v = {27'h0000000, s.ctrl};
         cfg_pin_pkg::LEN_OFS: v = {16'h0000, s.len};
         cfg_pin_pkg::STATUS_OFS: v = {s.byte_cnt, 12'h000, s.err, s.state};
         default: v = 32'h00000000;
      endcase
      return v;
   endfunction

   // ************************************************************
   // Input synchronisation and byte assembly
   // ************************************************************
   always_comb begin
      pins_raw.restart_n = config_restart_n;
      pins_raw.chain_en_n = chain_enable_n;
      pins_raw.cfg_clk = config_clock_in;
      pins_raw.cfg_data = serial_config_in;
      pins_raw.done_in = config_complete_flag_in;
      pins_raw.status_in = error_status_in;
      pins_raw.user_clk = user_init_clock;
      pins_raw.oe_pin = global_output_enable;
      pins_raw.clr_n = global_register_clear_n;
   end

   pin_sync u_sync (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .pins_in(pins_raw),
      .pins_out(pins)
   );

   serial_byte_assembler u_asm (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .clear(st_reg.clear_asm),
      .bit_valid(st_reg.bit_v),
      .bit_in(st_reg.bit_d),
      .byte_out(rx_byte)
   );

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      logic active;
      logic init_tick;
      logic last_byte;
      active = 1'b0;
      init_tick = 1'b0;
      last_byte = 1'b0;
      st_next = st_reg;
      st_next.restart_q = pins.restart_n;
      st_next.clk_q = pins.cfg_clk;
      st_next.uclk_q = pins.user_clk;
      st_next.bit_v = 1'b0;
      st_next.clear_asm = 1'b0;
      active = st_reg.ctrl[cfg_pin_pkg::CTRL_ACTIVE];
      // Internal init clock runs every cycle; the user clock only on its rising edges
      init_tick = st_reg.ctrl[cfg_pin_pkg::CTRL_USER_CLK] ? (pins.user_clk && !st_reg.uclk_q) : 1'b1;

      // Bus slave: answer one cycle after the request is seen
      st_next.wait_r = 1'b1;
      if ((avs_read || avs_write) && st_reg.wait_r) begin
         st_next.wait_r = 1'b0;
         st_next.rdata = reg_read(avs_address, st_reg);
      end
      if (avs_write && !st_reg.wait_r) begin
         case (avs_address)
            cfg_pin_pkg::CTRL_OFS: st_next.ctrl = avs_writedata[4:0];
            cfg_pin_pkg::LEN_OFS: st_next.len = avs_writedata[15:0];
            default: st_next.len = st_reg.len;
         endcase
      end

      case (st_reg.state)
         cfg_pin_pkg::ST_IDLE: begin
            if (pins.restart_n && !st_reg.restart_q && !pins.chain_en_n) begin
               st_next.state = cfg_pin_pkg::ST_LOAD;
               st_next.done_oe = 1'b1;
               st_next.init_oe = st_reg.ctrl[cfg_pin_pkg::CTRL_INIT_DONE];
               st_next.byte_cnt = 16'h0000;
               st_next.xsum = 8'h00;
               st_next.err = 1'b0;
               st_next.clear_asm = 1'b1;
               st_next.div = 4'h0;
               st_next.sclk = 1'b0;
               st_next.cmd_cnt = 6'h00;
               st_next.cmd_sh = cfg_pin_pkg::AS_READ_CMD;
               st_next.cmd_out = cfg_pin_pkg::AS_READ_CMD[31];
               st_next.clk_oe = active;
               st_next.cs_n = !active;
            end
         end
         cfg_pin_pkg::ST_LOAD: begin
            if (active) begin
               // Divider makes the memory clock; command goes out MSB first
               st_next.div = st_reg.div + 4'h1;
               if (st_reg.div == cfg_pin_pkg::AS_HALF_CYC - 4'h1) begin
                  st_next.div = 4'h0;
                  st_next.sclk = !st_reg.sclk;
                  if (!st_reg.sclk) begin
                     if (st_reg.cmd_cnt == cfg_pin_pkg::AS_CMD_BITS) begin
                        // Synchronised data is two cycles old, well inside the half period
                        st_next.bit_v = !pins.chain_en_n;
                        st_next.bit_d = pins.cfg_data;
                     end else begin
                        st_next.cmd_cnt = st_reg.cmd_cnt + 6'h01;
                     end
                  end else if (st_reg.cmd_cnt != cfg_pin_pkg::AS_CMD_BITS) begin
                     st_next.cmd_sh = {st_reg.cmd_sh[30:0], 1'b0};
                     st_next.cmd_out = st_reg.cmd_sh[30];
                  end
               end
            end else if (pins.cfg_clk && !st_reg.clk_q && !pins.chain_en_n) begin
               st_next.bit_v = 1'b1;
               st_next.bit_d = pins.cfg_data;
            end
            if (rx_byte.valid) begin
               st_next.byte_cnt = st_reg.byte_cnt + 16'h0001;
               st_next.xsum = st_reg.xsum ^ rx_byte.data;
               last_byte = (st_reg.byte_cnt + 16'h0001) == st_reg.len;
            end
            if (last_byte) begin
               // Final byte is the check byte: the whole frame must XOR to zero
               st_next.cs_n = 1'b1;
               st_next.clk_oe = 1'b0;
               st_next.sclk = 1'b0;
               if ((st_reg.xsum ^ rx_byte.data) == 8'h00) begin
                  st_next.state = cfg_pin_pkg::ST_RELEASE;
                  st_next.ceo_n = 1'b0;
               end else begin
                  st_next.state = cfg_pin_pkg::ST_ERROR;
                  st_next.err = 1'b1;
               end
            end
         end
         cfg_pin_pkg::ST_RELEASE: begin
            if (init_tick) begin
               st_next.done_oe = 1'b0;
               st_next.state = cfg_pin_pkg::ST_SENSE;
               st_next.init_cnt = 4'h0;
            end
         end
         cfg_pin_pkg::ST_SENSE: begin
            // A memory-driven load does not wait on an outside hold
            if (pins.done_in || active) begin
               st_next.state = cfg_pin_pkg::ST_INIT;
            end
         end
         cfg_pin_pkg::ST_INIT: begin
            if (init_tick) begin
               st_next.init_cnt = st_reg.init_cnt + 4'h1;
               if (st_reg.init_cnt == cfg_pin_pkg::INIT_CYCLES - 4'h1) begin
                  st_next.state = cfg_pin_pkg::ST_USER;
                  st_next.init_oe = 1'b0;
               end
            end
         end
         cfg_pin_pkg::ST_USER: begin
            st_next.state = cfg_pin_pkg::ST_USER;
         end
         cfg_pin_pkg::ST_ERROR: begin
            st_next.status_oe = 1'b1;
            st_next.cs_n = 1'b1;
            st_next.clk_oe = 1'b0;
         end
         default: st_next.state = cfg_pin_pkg::ST_IDLE;
      endcase

      // Outside hold on the error line during loading or initialisation aborts
      if (!pins.status_in && !st_reg.status_oe && (st_reg.state != cfg_pin_pkg::ST_IDLE) &&
          (st_reg.state != cfg_pin_pkg::ST_USER)) begin
         st_next.state = cfg_pin_pkg::ST_ERROR;
         st_next.err = 1'b1;
      end
      if (!pins.restart_n && st_reg.restart_q) begin
         st_next.state = cfg_pin_pkg::ST_IDLE;
         st_next.done_oe = 1'b1;
         st_next.status_oe = 1'b0;
         st_next.init_oe = 1'b0;
         st_next.ceo_n = 1'b1;
         st_next.cs_n = 1'b1;
         st_next.clk_oe = 1'b0;
         st_next.sclk = 1'b0;
      end

      // I/O held off until user mode, then the overrides apply
      st_next.tri_io = (st_next.state != cfg_pin_pkg::ST_USER) ||
         (st_reg.ctrl[cfg_pin_pkg::CTRL_OE_OVR] && !pins.oe_pin);
      st_next.clr_io = (st_next.state != cfg_pin_pkg::ST_USER) ||
         (st_reg.ctrl[cfg_pin_pkg::CTRL_CLR_OVR] && !pins.clr_n);
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         st_reg <= '0;
         st_reg.state <= cfg_pin_pkg::ST_IDLE;
         st_reg.ctrl <= cfg_pin_pkg::CTRL_RESET;
         st_reg.len <= cfg_pin_pkg::LEN_RESET;
         st_reg.wait_r <= 1'b1;
         st_reg.done_oe <= 1'b1;
         st_reg.cs_n <= 1'b1;
         st_reg.ceo_n <= 1'b1;
         st_reg.tri_io <= 1'b1;
         st_reg.clr_io <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign avs_readdata = st_reg.rdata;
   assign avs_waitrequest = st_reg.wait_r;
   assign config_clock_out = st_reg.sclk;
   assign config_clock_oe = st_reg.clk_oe;
   // Open-drain lines only ever drive low; their level field stays zero
   assign config_complete_flag_out = st_reg.bit_v & 1'b0;
   assign config_complete_flag_oe = st_reg.done_oe;
   assign error_status_out = st_reg.bit_v & 1'b0;
   assign error_status_oe = st_reg.status_oe;
   assign init_done_out = st_reg.bit_v & 1'b0;
   assign init_done_oe = st_reg.init_oe;
   assign active_serial_cmd_out = st_reg.cmd_out;
   assign flash_select_n = st_reg.cs_n;
   assign chain_enable_out_n = st_reg.ceo_n;
   assign user_io_tristate = st_reg.tri_io;
   assign user_reg_clear = st_reg.clr_io;
endmodule // config_pin_handshake

// ===== sim/config_pin_handshake_chk.sv
// Port checker for the configuration pin logic.
// Assumes it is bound into every instance of the block.
`timescale 1ns/1ps
module config_pin_handshake_chk (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic config_clock_out,
   input wire logic config_clock_oe,
   input wire logic config_complete_flag_oe,
   input wire logic error_status_oe,
   input wire logic init_done_oe,
   input wire logic active_serial_cmd_out,
   input wire logic flash_select_n,
   input wire logic chain_enable_out_n,
   input wire logic user_io_tristate,
   input wire logic user_reg_clear
);
   // ************************************************************
   // Properties
   // ************************************************************
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   logic clk_prev_reg;
   logic [3:0] half_reg;
   // Saturating count of cycles since the generated clock last moved
   always_ff @(posedge ref_clk) begin
      clk_prev_reg <= config_clock_out;
      if (!rst_b || config_clock_out != clk_prev_reg) begin
         half_reg <= 4'h0;
      end else if (half_reg != 4'hf) begin
         half_reg <= half_reg + 4'h1;
      end
   end
   property p_bus_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
   property p_bus_pulse; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_bus_pulse: assert property (p_bus_pulse) else $error("waitrequest low too long");
   property p_release; $fell(config_complete_flag_oe) |-> !chain_enable_out_n; endproperty
   a_release: assert property (p_release) else $error("completion released early");
   property p_chain_out; $fell(chain_enable_out_n) |-> ##[0:40] !config_complete_flag_oe; endproperty
   a_chain_out: assert property (p_chain_out) else $error("completion not released");
   property p_init_low; $rose(init_done_oe) |-> config_complete_flag_oe; endproperty
   a_init_low: assert property (p_init_low) else $error("status low outside load");
   property p_err_user; error_status_oe |-> user_io_tristate && user_reg_clear; endproperty
   a_err_user: assert property (p_err_user) else $error("error while in user mode");
   property p_tri_user; !user_io_tristate |-> !config_complete_flag_oe && !init_done_oe; endproperty
   a_tri_user: assert property (p_tri_user) else $error("outputs enabled before user mode");
   property p_clr_user; !user_reg_clear |-> !config_complete_flag_oe && !chain_enable_out_n; endproperty
   a_clr_user: assert property (p_clr_user) else $error("clear lifted before user mode");
   property p_select; config_clock_oe |-> !flash_select_n; endproperty
   a_select: assert property (p_select) else $error("clock driven without select");
   property p_half; config_clock_oe && $past(config_clock_oe) && config_clock_out != clk_prev_reg
      |-> half_reg >= 4'h7; endproperty
   a_half: assert property (p_half) else $error("generated clock half too short");
   property p_cmd_edge; $changed(active_serial_cmd_out) && !flash_select_n |-> !config_clock_out; endproperty
   a_cmd_edge: assert property (p_cmd_edge) else $error("command bit moved on high clock");
endmodule // config_pin_handshake_chk

bind config_pin_handshake config_pin_handshake_chk u_chk (
   .ref_clk(ref_clk), .rst_b(rst_b), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .config_clock_out(config_clock_out), .config_clock_oe(config_clock_oe),
   .config_complete_flag_oe(config_complete_flag_oe), .error_status_oe(error_status_oe),
   .init_done_oe(init_done_oe), .active_serial_cmd_out(active_serial_cmd_out), .flash_select_n(flash_select_n),
   .chain_enable_out_n(chain_enable_out_n), .user_io_tristate(user_io_tristate), .user_reg_clear(user_reg_clear)
);

// ===== sim/cfg_host_model.sv
// Passive configuration host: link clock, serial data, completion pull-up.
// Assumes its task is called right after a rising ref_clk edge.
`timescale 1ns/1ps
module cfg_host_model (
   input wire logic ref_clk,
   input wire logic complete_oe,
   input wire logic hold_low,
   output logic host_clk,
   output logic host_data,
   output logic complete_line
);
   // ************************************************************
   // Link side
   // ************************************************************
   // Open-drain line with pull-up; either party may hold it low
   assign complete_line = !(complete_oe || hold_low);
   initial begin
      host_clk = 1'b0;
      host_data = 1'b1;
   end
   // Clock stands low between frames; 8 ref_clk per half gives 80 ns
   task automatic send_byte(input logic [7:0] b);
      host_data <= b[0];
      for (int i = 0; i < 8; i++) begin
         repeat (8) @(posedge ref_clk);
         host_clk <= 1'b1;
         repeat (8) @(posedge ref_clk);
         host_clk <= 1'b0;
         // Hold ends with the fall, so a stale bit is never left on the line
         host_data <= (i < 7) ? b[i + 1] : !b[7];
      end
      @(posedge ref_clk);
   endtask
endmodule // cfg_host_model

// ===== sim/test_config_pin_handshake.sv
// Self-checking bench for the configuration pin logic.
// Assumes the package, design, checker and host model are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module test_config_pin_handshake;
   typedef struct packed {logic wr; logic [3:0] a; logic [31:0] d; logic [31:0] e;} row_t;
   logic ref_clk, rst_b, avs_read, avs_write, avs_waitrequest, config_restart_n, chain_enable_n;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q, cmd;
   logic serial_config_in, config_clock_in, config_clock_out, config_clock_oe, complete_in, complete_oe;
   logic error_in, error_oe, init_oe, active_serial_cmd_out, flash_select_n, chain_enable_out_n;
   logic user_init_clock, goe, clr_n, tri_o, clr_o, hold_low, host_clk, init_q;
   logic [2:0] od_o;
   int rises = 0;
   int errors = 0;
   int compares = 0;
   int cycles = 0;
   row_t rows [10] = '{'{1'b0, 4'h0, 32'h0, 32'h0}, '{1'b0, 4'h4, 32'h0, 32'h10},
      '{1'b1, 4'hc, 32'hffffffff, 32'h0}, '{1'b0, 4'hc, 32'h0, 32'h0}, '{1'b1, 4'h4, 32'hffff0002, 32'h0},
      '{1'b0, 4'h4, 32'h0, 32'h2}, '{1'b1, 4'h0, 32'hfffffff6, 32'h0}, '{1'b0, 4'h0, 32'h0, 32'h16},
      '{1'b1, 4'h8, 32'hffffffff, 32'h0}, '{1'b0, 4'h8, 32'h0, 32'h0}};
   // ************************************************************
   // Wiring
   // ************************************************************
   assign error_in = !error_oe;
   assign config_clock_in = config_clock_oe ? config_clock_out : host_clk;
   config_pin_handshake u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .config_restart_n(config_restart_n), .chain_enable_n(chain_enable_n),
      .serial_config_in(serial_config_in), .config_clock_in(config_clock_in), .config_clock_out(config_clock_out),
      .config_clock_oe(config_clock_oe), .config_complete_flag_in(complete_in), .config_complete_flag_out(od_o[0]),
      .config_complete_flag_oe(complete_oe), .error_status_in(error_in), .error_status_out(od_o[1]),
      .error_status_oe(error_oe), .init_done_out(od_o[2]), .init_done_oe(init_oe),
      .active_serial_cmd_out(active_serial_cmd_out), .flash_select_n(flash_select_n),
      .chain_enable_out_n(chain_enable_out_n), .user_init_clock(user_init_clock), .global_output_enable(goe),
      .global_register_clear_n(clr_n), .user_io_tristate(tri_o), .user_reg_clear(clr_o));
   cfg_host_model u_host (.ref_clk(ref_clk), .complete_oe(complete_oe), .hold_low(hold_low),
      .host_clk(host_clk), .host_data(serial_config_in), .complete_line(complete_in));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = !ref_clk;
   end
   initial begin
      user_init_clock = 1'b0;
      forever #40 user_init_clock = !user_init_clock;
   end
   // A hang costs a mismatch rather than an endless run
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      // User mode is a rise of the status line; its level is high before loading too
      init_q <= init_oe;
      if (init_q && !init_oe) begin
         rises <= rises + 1;
      end
      if (cycles == 5000) begin
         errors++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, wr, !wr};
      // Ends when waitrequest goes low; if it never does, the bench timeout ends the run
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
      r = avs_readdata;
      {avs_write, avs_read} <= 2'h0;
      @(posedge ref_clk);
   endtask
   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      rst_b = 1'b0;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      {config_restart_n, chain_enable_n, hold_low, goe, clr_n} = 5'h03;
      repeat (20) @(posedge ref_clk);
      `CHK({avs_waitrequest, complete_oe, init_oe, flash_select_n, chain_enable_out_n, tri_o, clr_o}, 7'h6f)
      rst_b <= 1'b1;
      @(posedge ref_clk);
      foreach (rows[i]) begin
         bus(rows[i].wr, rows[i].a, rows[i].d, q);
         if (!rows[i].wr) `CHK(q, rows[i].e)
      end
      $display("done registers");
      bus(1'b1, 4'h0, 32'h1e, q);
      config_restart_n <= 1'b1;
      repeat (10) @(posedge ref_clk);
      `CHK({init_oe, complete_oe}, 2'h3)
      hold_low <= 1'b1;
      u_host.send_byte(8'ha5);
      u_host.send_byte(8'ha5);
      while (chain_enable_out_n !== 1'b0) @(posedge ref_clk);
      repeat (40) @(posedge ref_clk);
      bus(1'b0, 4'h8, 32'h0, q);
      `CHK({complete_oe, tri_o, q[2:0]}, 5'h0e)
      hold_low <= 1'b0;
      while (tri_o !== 1'b0) @(posedge ref_clk);
      bus(1'b0, 4'h8, 32'h0, q);
      `CHK({init_oe, clr_o, q[31:16], q[2:0]}, {2'h0, 16'h0002, 3'h4})
      `CHK(rises, 1)
      $display("done passive frame");
      goe <= 1'b0;
      clr_n <= 1'b0;
      repeat (8) @(posedge ref_clk);
      `CHK({tri_o, clr_o}, 2'h3)
      {goe, clr_n, hold_low} <= 3'h7;
      u_host.send_byte(8'h00);
      bus(1'b0, 4'h8, 32'h0, q);
      `CHK({tri_o, clr_o, error_oe, q[31:16], q[2:0]}, {3'h0, 16'h0002, 3'h4})
      hold_low <= 1'b0;
      $display("done user mode");
      config_restart_n <= 1'b0;
      repeat (8) @(posedge ref_clk);
      bus(1'b0, 4'h8, 32'h0, q);
      `CHK({complete_oe, chain_enable_out_n, init_oe, q[2:0]}, 6'h30)
      config_restart_n <= 1'b1;
      repeat (10) @(posedge ref_clk);
      u_host.send_byte(8'ha5);
      u_host.send_byte(8'h00);
      repeat (10) @(posedge ref_clk);
      bus(1'b0, 4'h8, 32'h0, q);
      `CHK({error_oe, q[3], q[2:0], od_o}, 8'he8)
      $display("done error frame");
      config_restart_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      bus(1'b1, 4'h0, 32'h1, q);
      config_restart_n <= 1'b1;
      while (flash_select_n !== 1'b0) @(posedge ref_clk);
      `CHK(config_clock_oe, 1'b1)
      for (int i = 0; i < 32; i++) begin
         while (config_clock_out !== 1'b0) @(posedge ref_clk);
         while (config_clock_out !== 1'b1) @(posedge ref_clk);
         cmd = {cmd[30:0], active_serial_cmd_out};
      end
      `CHK(cmd, cfg_pin_pkg::AS_READ_CMD)
      $display("done active mode");
      end_of_test();
   end
endmodule // test_config_pin_handshake
